//--- src/scet_defines.vh
`ifndef SCET_DEFINES_VH
`define SCET_DEFINES_VH

// ****************************************************************
// Register word addresses (byte offsets, one aligned word each).
// ****************************************************************
`define SCET_ADDR_MODE      8'h00
`define SCET_ADDR_ALARM     8'h04
`define SCET_ADDR_VALUE     8'h08
`define SCET_ADDR_STATUS    8'h0c

// ****************************************************************
// Mode register field positions.
// ****************************************************************
`define SCET_MODE_PRES_MSB  15
`define SCET_MODE_PRES_LSB  0
`define SCET_MODE_ALARM_IRQ_ENABLE    16
`define SCET_MODE_INCIEN    17
`define SCET_MODE_RESTART   18
`define SCET_MODE_DISABLE   20
`define SCET_MODE_ONEHZ     24

// ****************************************************************
// Status register field positions.
// ****************************************************************
`define SCET_STAT_ALARM     0
`define SCET_STAT_INC       1

// ****************************************************************
// Reset values.
// ****************************************************************
`define SCET_PRES_RESET     16'h8000
`define SCET_ALARM_RESET    32'hffffffff

// ****************************************************************
// Timing: the interrupt output follows a status read after this
// many slow clock cycles.
// ****************************************************************
`define SCET_IRQ_READ_SLOW  2'h2

`endif

//--- src/scet_edge_sync.v
`timescale 1ns/1ns

// ****************************************************************
// Two-stage synchroniser with rising edge pulse per input bit.
// ****************************************************************
module scet_edge_sync #(
    parameter WIDTH = 2                  // Number of input levels.
) (
    // Clock and reset.
    input  wire             clk_i,
    input  wire             rst_i,
    // Levels in and one-cycle rising edge pulses out.
    input  wire [WIDTH-1:0] level_i,
    output wire [WIDTH-1:0] rise_o
);

    reg [WIDTH-1:0] meta_reg;            // First stage, read only below.
    reg [WIDTH-1:0] sync_reg;            // Second stage, safe level.
    reg [WIDTH-1:0] last_reg;            // Previous safe level.

    genvar gi;

    // ************************************************************
    // One synchroniser and edge detector for each bit.
    // ************************************************************
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            // The first stage feeds only the second stage.
            always @(posedge clk_i) begin
                if (rst_i) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                    last_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= level_i[gi];
                    sync_reg[gi] <= meta_reg[gi];
                    last_reg[gi] <= sync_reg[gi];
                end
            end
            // A rise is a new high after a low.
            assign rise_o[gi] = sync_reg[gi] & ~last_reg[gi];
        end
    endgenerate

endmodule // scet_edge_sync

//--- src/scet_timer.v
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`include "scet_defines.vh"

// Contract
// - Setting N above zero rolls every N ticks.
// - Setting zero rolls every 65536 ticks.
// - Setting resets to 0x8000, one second.
// - Source select zero: roll-over increments counter.
// - Source select one: 1 Hz tick increments.
// - Increment flag set on every roll-over.
// - Counter wraps from all ones to zero.
// - Alarm flag rises as counter reaches alarm+1.
// - Alarm value resets to all ones.
// - Alarm flag always drives wake-up output.
// - Interrupt gated by each flag's enable.
// - Status read returns then clears both flags.
// - Interrupt reacts two slow cycles after read.
// - Restart reloads divider and zeroes counter.
// - Disable stops timer; disable and select write-only.
module scet_timer (
    // System clock and synchronous reset.
    input  wire        clk_i,
    input  wire        rst_i,
    // Slow clock and calibrated one-second tick, sampled levels.
    input  wire        slow_clock_i,
    input  wire        one_hz_tick_i,
    // Classic Wishbone slave.
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Interrupt and wake-up outputs.
    output reg         irq_o,
    output reg         alarm_o
);

    // ************************************************************
    // Declarations.
    // ************************************************************
    reg  [15:0] prescale_setting_reg;    // Prescaler period setting.
    reg         alarm_irq_enable_reg;    // Alarm interrupt enable.
    reg         increment_irq_enable_reg;// Increment interrupt enable.
    reg         disable_bit_reg;         // Timer stopped when high.
    reg         one_hz_source_select_reg;// Counter source select.
    reg  [31:0] alarm_value_reg;         // Alarm compare value.
    reg  [15:0] prescale_count_reg;      // Prescaler position.
    reg  [31:0] current_count_reg;       // Elapsed-time counter.
    reg         increment_flag_reg;      // Sticky roll-over flag.
    reg         alarm_flag_reg;          // Sticky alarm flag.
    reg  [1:0]  irq_hold_reg;            // Slow cycles left to hold.

    wire [1:0]  tick_rise;               // Edge pulses from sync.
    wire        slow_tick;               // One pulse per slow cycle.
    wire        one_hz_tick;             // One pulse per second.
    wire        access;                  // New bus request this cycle.
    wire        wr_access;               // New write request.
    wire        rd_status;               // Status register read.
    wire        wr_mode;                 // Mode register write.
    wire        restart;                 // Restart requested.
    wire        running;                 // Timer not disabled.
    wire        roll_over;               // Prescaler wraps this cycle.
    wire        count_step;              // Counter advances.
    wire        alarm_hit;               // Counter steps past alarm.
    wire        irq_source;              // Enabled flag present.
    wire [31:0] wr_merged_mode;          // Mode write after lanes.
    wire [31:0] wr_merged_alarm;         // Alarm write after lanes.
    wire [31:0] mode_image;              // Mode readback.
    reg  [31:0] rd_data;                 // Read mux result.

    // ************************************************************
    // Input synchronisers for slow clock and one-second tick.
    // ************************************************************
    scet_edge_sync #(
        .WIDTH   (2)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i ({one_hz_tick_i, slow_clock_i}),
        .rise_o  (tick_rise)
    );

    assign slow_tick   = tick_rise[0];
    assign one_hz_tick = tick_rise[1];

    // ************************************************************
    // Bus decode; a request is served once, in its first cycle.
    // ************************************************************
    assign access    = cyc_i & stb_i & ~ack_o;
    assign wr_access = access & we_i;
    assign rd_status = access & ~we_i & (adr_i == `SCET_ADDR_STATUS);
    assign wr_mode   = wr_access & (adr_i == `SCET_ADDR_MODE);

    // Byte lanes merge the write data with the current contents.
    genvar gl;
    generate
        for (gl = 0; gl < 4; gl = gl + 1) begin : g_lane
            assign wr_merged_mode[gl*8+7:gl*8] = sel_i[gl] ?
                dat_i[gl*8+7:gl*8] : mode_image[gl*8+7:gl*8];
            assign wr_merged_alarm[gl*8+7:gl*8] = sel_i[gl] ?
                dat_i[gl*8+7:gl*8] : alarm_value_reg[gl*8+7:gl*8];
        end
    endgenerate

    // Restart and write-only bits read back as zero.
    assign mode_image = {14'h0000,
                         increment_irq_enable_reg,
                         alarm_irq_enable_reg,
                         prescale_setting_reg};

    // Restart acts only when its lane is enabled and written one.
    assign restart = wr_mode & sel_i[2] & dat_i[`SCET_MODE_RESTART];

    // ************************************************************
    // Prescaler and counter stepping.
    // ************************************************************
    assign running = ~disable_bit_reg;
    // Setting minus one wraps to all ones, so zero gives 65536.
    assign roll_over = running & slow_tick &
        (prescale_count_reg == prescale_setting_reg - 16'h0001);
    assign count_step = running &
        (one_hz_source_select_reg ? one_hz_tick : roll_over);
    assign alarm_hit = count_step &
        (current_count_reg == alarm_value_reg);

    // ************************************************************
    // Mode and alarm registers written by software.
    // ************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            prescale_setting_reg     <= `SCET_PRES_RESET;
            alarm_irq_enable_reg     <= 1'b0;
            increment_irq_enable_reg <= 1'b0;
            disable_bit_reg          <= 1'b0;
            one_hz_source_select_reg <= 1'b0;
            alarm_value_reg          <= `SCET_ALARM_RESET;
        end else begin
            // Mode write updates setting, enables and controls.
            if (wr_mode) begin
                prescale_setting_reg <=
                    wr_merged_mode[`SCET_MODE_PRES_MSB:`SCET_MODE_PRES_LSB];
                alarm_irq_enable_reg <= wr_merged_mode[`SCET_MODE_ALARM_IRQ_ENABLE];
                increment_irq_enable_reg <=
                    wr_merged_mode[`SCET_MODE_INCIEN];
                // Write-only bits change only when their lane is sent.
                if (sel_i[2]) begin
                    disable_bit_reg <= dat_i[`SCET_MODE_DISABLE];
                end
                if (sel_i[3]) begin
                    one_hz_source_select_reg <= dat_i[`SCET_MODE_ONEHZ];
                end
            end
            // Alarm write takes the merged lanes.
            if (wr_access && adr_i == `SCET_ADDR_ALARM) begin
                alarm_value_reg <= wr_merged_alarm;
            end
        end
    end

    // ************************************************************
    // Prescaler position and elapsed-time counter.
    // ************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            prescale_count_reg <= 16'h0000;
            current_count_reg  <= 32'h00000000;
        end else if (restart) begin
            // Divider restarts with the new setting, counter clears.
            prescale_count_reg <= 16'h0000;
            current_count_reg  <= 32'h00000000;
        end else begin
            // The divider holds while disabled.
            if (roll_over) begin
                prescale_count_reg <= 16'h0000;
            end else if (running && slow_tick) begin
                prescale_count_reg <= prescale_count_reg + 16'h0001;
            end
            // Natural 32-bit wrap from all ones to zero.
            if (count_step) begin
                current_count_reg <= current_count_reg + 32'h00000001;
            end
        end
    end

    // ************************************************************
    // Sticky event flags, cleared by a status read.
    // ************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            increment_flag_reg <= 1'b0;
            alarm_flag_reg     <= 1'b0;
        end else begin
            // A set in the read cycle wins over the clear.
            if (roll_over) begin
                increment_flag_reg <= 1'b1;
            end else if (rd_status) begin
                increment_flag_reg <= 1'b0;
            end
            if (alarm_hit) begin
                alarm_flag_reg <= 1'b1;
            end else if (rd_status) begin
                alarm_flag_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Interrupt and wake-up outputs.
    // ************************************************************
    assign irq_source = (alarm_flag_reg & alarm_irq_enable_reg) |
        (increment_flag_reg & increment_irq_enable_reg);

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_o        <= 1'b0;
            alarm_o      <= 1'b0;
            irq_hold_reg <= 2'h0;
        end else begin
            // Wake-up follows the alarm flag regardless of enables.
            alarm_o <= alarm_flag_reg;
            if (rd_status) begin
                // Freeze the interrupt for two slow cycles.
                irq_hold_reg <= `SCET_IRQ_READ_SLOW;
            end else if (irq_hold_reg != 2'h0) begin
                if (slow_tick) begin
                    irq_hold_reg <= irq_hold_reg - 2'h1;
                end
            end else begin
                irq_o <= irq_source;
            end
        end
    end

    // ************************************************************
    // Read multiplexer; unmapped addresses read as zero.
    // ************************************************************
    always @* begin
        rd_data = 32'h00000000;
        case (adr_i)
            `SCET_ADDR_MODE: begin
                rd_data = mode_image;
            end
            `SCET_ADDR_ALARM: begin
                rd_data = alarm_value_reg;
            end
            `SCET_ADDR_VALUE: begin
                rd_data = current_count_reg;
            end
            `SCET_ADDR_STATUS: begin
                rd_data[`SCET_STAT_ALARM] = alarm_flag_reg;
                rd_data[`SCET_STAT_INC]   = increment_flag_reg;
            end
            default: begin
                rd_data = 32'h00000000;
            end
        endcase
    end

    // ************************************************************
    // Acknowledge and read data, one cycle after the request.
    // ************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            // Every address is answered; writes elsewhere are dropped.
            ack_o <= access;
            if (access && !we_i) begin
                dat_o <= rd_data;
            end
        end
    end

endmodule // scet_timer

//--- bench/scet_checker_assertions.sv
`timescale 1ns/1ns
`include "scet_defines.vh"

// ****************************************************************
// Bus and output checks for the elapsed time timer.
// ****************************************************************
module scet_checker (
    // Clock and reset.
    input wire        clk_i,
    input wire        rst_i,
    // Bus and outputs watched.
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire        irq_o
);
    // A request is taken on an edge with no ack pending.
    wire take = cyc_i && stb_i && !ack_o;
    // A read taken on this edge.
    wire rd   = take && !we_i;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_follows: assert property (take |=> ack_o)
        else $error("ack missing one cycle after request");
    a_ack_cause: assert property (ack_o |-> $past(take))
        else $error("ack without a request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_data_hold: assert property ($changed(dat_o) |-> ack_o)
        else $error("read data changed without ack");
    a_mode_wo: assert property (
        rd && adr_i == `SCET_ADDR_MODE |=> dat_o[31:18] == 14'h0000)
        else $error("write-only mode bits read back");
    a_stat_bits: assert property (
        rd && adr_i == `SCET_ADDR_STATUS |=> dat_o[31:2] == 30'h0)
        else $error("status has bits beyond the two flags");
    a_unmapped_zero: assert property (
        rd && adr_i > `SCET_ADDR_STATUS |=> dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_irq_freeze: assert property (
        rd && adr_i == `SCET_ADDR_STATUS |=> ##1 $stable(irq_o)[*2])
        else $error("interrupt moved at once after status read");
endmodule // scet_checker

bind scet_timer scet_checker u_scet_checker (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o));

//--- bench/scet_testbench.sv
`timescale 1ns/1ns
`include "scet_defines.vh"

// ****************************************************************
// Self-checking bench: bus tasks, slow clock pulses, scenarios.
// ****************************************************************
module testbench;
    reg         clk_i = 1'b0;    // System clock.
    reg         rst_i = 1'b1;    // Synchronous reset.
    reg         slow_clock_i = 1'b0;
    reg         one_hz_tick_i = 1'b0;
    reg         cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    reg  [7:0]  adr_i = 8'h00;
    reg  [3:0]  sel_i = 4'h0;
    reg  [31:0] dat_i = 32'h00000000;
    wire [31:0] dat_o;
    wire        ack_o, irq_o, alarm_o;
    integer     failures = 0, n_compared = 0;
    reg  [31:0] q;               // Last read data.

    scet_timer u_scet_timer (.clk_i(clk_i), .rst_i(rst_i),
        .slow_clock_i(slow_clock_i), .one_hz_tick_i(one_hz_tick_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .irq_o(irq_o), .alarm_o(alarm_o));

    // The clock toggles every half period of 10 ns.
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // Counts a comparison and reports a mismatch.
    task check(input [8*8-1:0] name, input [31:0] exp, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if (exp !== got) begin
                failures = failures + 1;
                $display("BAD %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    // One classic bus cycle; holds the request until ack is sampled.
    task wb(input [7:0] a, input w, input [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge clk_i);
            cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w;
            adr_i <= a; dat_i <= d; sel_i <= 4'hf;
            @(posedge clk_i);
            while (ack_o !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge clk_i);
            end
            q = dat_o;
            cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
            check("ack", 32'h1, {31'h0, ack_o});
        end
    endtask

    // Reads a register and compares it.
    task rd(input [7:0] a, input [8*8-1:0] name, input [31:0] exp);
        begin
            wb(a, 1'b0, 32'h0);
            check(name, exp, q);
        end
    endtask

    // Mode word: setting, alarm and increment enables, restart,
    // disable and one second source select.
    function [31:0] md(input [15:0] p, input [4:0] f);
        md = {7'h00, f[4], 3'h0, f[3], 1'b0, f[2:0], p};
    endfunction

    // Slow (or one second) rising edges, 4 clocks high and 4 low.
    task ticks(input integer n, input hz);
        begin
            repeat (n) begin
                repeat (4) @(posedge clk_i);
                if (hz) one_hz_tick_i <= 1'b1; else slow_clock_i <= 1'b1;
                repeat (4) @(posedge clk_i);
                one_hz_tick_i <= 1'b0; slow_clock_i <= 1'b0;
            end
            repeat (4) @(posedge clk_i);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task end_sim;
        begin
            $display("compared %0d failures %0d", n_compared, failures);
            if (failures == 0 && n_compared > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // Cuts a hang short.
    initial begin
        #400000;
        failures = failures + 1;
        end_sim;
    end

    // Main sequence.
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h00, "mode", 32'h00008000);
        rd(8'h04, "alarm", 32'hffffffff);
        rd(8'h08, "value", 32'h0);
        rd(8'h10, "unmapped", 32'h0);
        // Counting from the prescaler, setting three.
        wb(8'h00, 1'b1, md(16'h0003, 5'h04));
        ticks(9, 1'b0);
        rd(8'h08, "value", 32'h3);
        rd(8'h0c, "status", 32'h2);
        ticks(2, 1'b0);
        rd(8'h08, "value", 32'h3);
        rd(8'h08, "value", 32'h3);
        rd(8'h0c, "status", 32'h0);
        wb(8'h00, 1'b1, md(16'h0003, 5'h04));
        rd(8'h08, "value", 32'h0);
        // Alarm at two: flag comes as the count reaches three.
        wb(8'h04, 1'b1, 32'h2);
        ticks(6, 1'b0);
        rd(8'h08, "value", 32'h2);
        check("alarm_o", 32'h0, {31'h0, alarm_o});
        rd(8'h0c, "status", 32'h2);
        ticks(3, 1'b0);
        rd(8'h08, "value", 32'h3);
        check("alarm_o", 32'h1, {31'h0, alarm_o});
        check("irq_o", 32'h0, {31'h0, irq_o});
        rd(8'h0c, "status", 32'h3);
        rd(8'h0c, "status", 32'h0);
        check("alarm_o", 32'h0, {31'h0, alarm_o});
        wb(8'h04, 1'b1, 32'hffffffff);
        // Increment interrupt, then frozen after the status read.
        wb(8'h00, 1'b1, md(16'h0003, 5'h06));
        ticks(3, 1'b0);
        check("irq_o", 32'h1, {31'h0, irq_o});
        rd(8'h0c, "status", 32'h2);
        check("irq_o", 32'h1, {31'h0, irq_o});
        ticks(2, 1'b0);
        check("irq_o", 32'h0, {31'h0, irq_o});
        // One second source drives the count, prescaler the flag.
        wb(8'h00, 1'b1, md(16'h0003, 5'h14));
        ticks(2, 1'b1);
        rd(8'h08, "value", 32'h2);
        rd(8'h0c, "status", 32'h0);
        ticks(3, 1'b0);
        rd(8'h08, "value", 32'h2);
        rd(8'h0c, "status", 32'h2);
        // Disabled timer holds and sets nothing.
        wb(8'h00, 1'b1, md(16'h0003, 5'h04));
        ticks(2, 1'b0);
        wb(8'h00, 1'b1, md(16'h0003, 5'h08));
        ticks(4, 1'b0);
        rd(8'h08, "value", 32'h0);
        rd(8'h0c, "status", 32'h0);
        wb(8'h00, 1'b1, md(16'h0003, 5'h00));
        ticks(1, 1'b0);
        rd(8'h08, "value", 32'h1);
        rd(8'h0c, "status", 32'h2);
        end_sim;
    end
endmodule // testbench
